/* File: acc_pkg.sv */
// Constants, types and register map of the converter control block.
// Assumes an AHB-Lite bus at 100 MHz and one analog core on the far side.
package acc_pkg;

   localparam int unsigned ADDR_W = 4;
   localparam int unsigned DATA_W = 8;
   localparam int unsigned SEL_W = 5;
   localparam int unsigned ROUTE_W = 6;

   // Register byte offsets
   localparam logic [ADDR_W-1:0] OFS_SCR = 4'h0;
   localparam logic [ADDR_W-1:0] OFS_RESULT = 4'h4;
   localparam logic [ADDR_W-1:0] OFS_IRQ_STAT = 4'h8;
   localparam logic [ADDR_W-1:0] OFS_IRQ_MASK = 4'hC;

   // Status/control field positions
   localparam int unsigned SCR_DONE_BIT = 7;
   localparam int unsigned SCR_IRQ_EN_BIT = 6;
   localparam int unsigned SCR_CONT_BIT = 5;
   localparam int unsigned SCR_SEL_LSB = 0;

   // Reset values
   localparam logic [SEL_W-1:0] SEL_POWER_OFF = 5'h1F;
   localparam logic [DATA_W-1:0] RESULT_RST = 8'h00;
   localparam logic IRQ_MASK_RST = 1'b0;

   // Input select codes
   localparam logic [SEL_W-1:0] SEL_EXT_0 = 5'h00;
   localparam logic [SEL_W-1:0] SEL_EXT_1 = 5'h01;
   localparam logic [SEL_W-1:0] SEL_EXT_2 = 5'h02;
   localparam logic [SEL_W-1:0] SEL_EXT_3 = 5'h03;
   localparam logic [SEL_W-1:0] SEL_RESERVED = 5'h1B;
   localparam logic [SEL_W-1:0] SEL_HIGH_REF = 5'h1D;
   localparam logic [SEL_W-1:0] SEL_GND_REF = 5'h1E;

   // One-hot route positions
   localparam int unsigned ROUTE_EXT_0 = 0;
   localparam int unsigned ROUTE_EXT_1 = 1;
   localparam int unsigned ROUTE_EXT_2 = 2;
   localparam int unsigned ROUTE_EXT_3 = 3;
   localparam int unsigned ROUTE_HIGH_REF = 4;
   localparam int unsigned ROUTE_GND_REF = 5;

   // Port A pins carrying the external inputs
   localparam int unsigned PORT_A_W = 8;
   localparam int unsigned PIN_EXT_0 = 0;
   localparam int unsigned PIN_EXT_1 = 1;
   localparam int unsigned PIN_EXT_2 = 4;
   localparam int unsigned PIN_EXT_3 = 5;

   // AHB encodings
   localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
   localparam logic [1:0] HTRANS_SEQ = 2'h3;
   localparam logic HRESP_OKAY = 1'b0;

   typedef enum logic [1:0] {
      SEQ_IDLE = 2'b00,
      SEQ_SETTLE = 2'b01,
      SEQ_RUN = 2'b10
   } acc_seq_state_type;

endpackage : acc_pkg

/* File: acc_sequencer.sv */
// Conversion sequencer: settling, single and continuous conversions.
// Assumes the core restarts on every start pulse and answers with done.
`timescale 1ns/1ns
module acc_sequencer (
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic restart,
   input wire logic cont_mode,
   input wire logic power_on,
   input wire logic core_done,
   output logic core_start,
   output logic result_we,
   output logic busy
);
   import acc_pkg::*;

   typedef struct packed {
      acc_seq_state_type state;
      logic settle_needed;
      logic start;
      logic we;
   } acc_seq_reg_type;

   acc_seq_reg_type r_q;
   acc_seq_reg_type r_d;

   always_comb begin
      r_d = r_q;
      r_d.start = 1'b0;
      r_d.we = 1'b0;
      if (!power_on) begin
         // Power-off stops everything and forces a settling pass later
         r_d.state = SEQ_IDLE;
         r_d.settle_needed = 1'b1;
      end else if (restart) begin
         // A new start wins over any conversion still running
         r_d.start = 1'b1;
         r_d.state = r_q.settle_needed ? SEQ_SETTLE : SEQ_RUN;
      end else if (core_done) begin
         unique case (r_q.state)
            SEQ_IDLE: begin
               r_d.state = SEQ_IDLE;
            end
            SEQ_SETTLE: begin
               // Settling result is thrown away, real one follows
               r_d.settle_needed = 1'b0;
               r_d.start = 1'b1;
               r_d.state = SEQ_RUN;
            end
            SEQ_RUN: begin
               r_d.we = 1'b1;
               if (cont_mode) begin
                  r_d.start = 1'b1;
               end else begin
                  r_d.state = SEQ_IDLE;
               end
            end
            default: begin
               r_d.state = SEQ_IDLE;
            end
         endcase
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         r_q.state <= SEQ_IDLE;
         r_q.settle_needed <= 1'b1;
         r_q.start <= 1'b0;
         r_q.we <= 1'b0;
      end else begin
         r_q <= r_d;
      end
   end

   assign core_start = r_q.start;
   assign result_we = r_q.we;
   assign busy = (r_q.state != SEQ_IDLE);

endmodule : acc_sequencer

/* File: acc_conv_ctrl.sv */
// Converter control top: AHB-Lite register slave, input routing, interrupt.
// Assumes an analog core that converts on core_start and pulses core_done.
//
// Chosen here: register access over AHB-Lite and the register addresses.
`timescale 1ns/1ns
module acc_conv_ctrl (
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic [31:0] hrdata,
   output logic hreadyout,
   output logic hresp,
   input wire logic core_done,
   input wire logic [acc_pkg::DATA_W-1:0] core_data,
   output logic core_start,
   output logic core_power_en,
   output logic [acc_pkg::ROUTE_W-1:0] analog_route,
   output logic [acc_pkg::PORT_A_W-1:0] port_a_analog_en,
   output logic irq
);
   import acc_pkg::*;

   typedef struct packed {
      logic dp_act;
      logic dp_write;
      logic [ADDR_W-1:0] dp_addr;
      logic irq_en;
      logic cont;
      logic [SEL_W-1:0] sel;
      logic done;
      logic [DATA_W-1:0] result;
      logic [DATA_W-1:0] core_hold;
      logic irq_stat;
      logic irq_mask;
      logic [31:0] rdata;
      logic irq_out;
      logic power_en;
      logic [ROUTE_W-1:0] route;
      logic [PORT_A_W-1:0] pin_en;
      logic restart;
   } acc_reg_type;

   acc_reg_type r_q;
   acc_reg_type r_d;

   logic seq_start;
   logic seq_we;
   logic seq_busy;
   logic ap_take;
   logic ap_read;
   logic [ADDR_W-1:0] ap_addr;
   logic wr_scr;
   logic wr_stat;
   logic wr_mask;
   logic rd_result;
   logic [DATA_W-1:0] scr_view;

   // Select code to one-hot analog route; unused codes route nothing
   function automatic logic [ROUTE_W-1:0] route_of(
      input logic [SEL_W-1:0] s
   );
      logic [ROUTE_W-1:0] r;
      r = '0;
      unique case (s)
         SEL_EXT_0: r[ROUTE_EXT_0] = 1'b1;
         SEL_EXT_1: r[ROUTE_EXT_1] = 1'b1;
         SEL_EXT_2: r[ROUTE_EXT_2] = 1'b1;
         SEL_EXT_3: r[ROUTE_EXT_3] = 1'b1;
         SEL_HIGH_REF: r[ROUTE_HIGH_REF] = 1'b1;
         SEL_GND_REF: r[ROUTE_GND_REF] = 1'b1;
         default: r = '0;
      endcase
      return r;
   endfunction : route_of

   // Port A pins switched to analog use for a given select code
   function automatic logic [PORT_A_W-1:0] pins_of(
      input logic [SEL_W-1:0] s
   );
      logic [ROUTE_W-1:0] r;
      logic [PORT_A_W-1:0] p;
      r = route_of(s);
      p = '0;
      p[PIN_EXT_0] = r[ROUTE_EXT_0];
      p[PIN_EXT_1] = r[ROUTE_EXT_1];
      p[PIN_EXT_2] = r[ROUTE_EXT_2];
      p[PIN_EXT_3] = r[ROUTE_EXT_3];
      return p;
   endfunction : pins_of

   function automatic logic powered(input logic [SEL_W-1:0] s);
      return s != SEL_POWER_OFF;
   endfunction : powered

   acc_sequencer u_seq (
      .hclk(hclk),
      .hresetn(hresetn),
      .restart(r_q.restart),
      .cont_mode(r_q.cont),
      .power_on(r_q.power_en),
      .core_done(core_done),
      .core_start(seq_start),
      .result_we(seq_we),
      .busy(seq_busy)
   );

   // Address phase decode
   assign ap_take = hsel && hready &&
                    (htrans == HTRANS_NONSEQ || htrans == HTRANS_SEQ);
   assign ap_read = ap_take && !hwrite;
   assign ap_addr = haddr[ADDR_W-1:0];

   // Data phase write strobes, data sampled in the data phase; result read strobe in the address phase
   assign wr_scr = r_q.dp_act && r_q.dp_write && r_q.dp_addr == OFS_SCR;
   assign wr_stat = r_q.dp_act && r_q.dp_write &&
                    r_q.dp_addr == OFS_IRQ_STAT;
   assign wr_mask = r_q.dp_act && r_q.dp_write &&
                    r_q.dp_addr == OFS_IRQ_MASK;
   assign rd_result = ap_read && ap_addr == OFS_RESULT;

   always_comb begin
      scr_view = '0;
      scr_view[SCR_DONE_BIT] = r_q.done;
      scr_view[SCR_IRQ_EN_BIT] = r_q.irq_en;
      scr_view[SCR_CONT_BIT] = r_q.cont;
      scr_view[SCR_SEL_LSB +: SEL_W] = r_q.sel;
   end

   always_comb begin
      r_d = r_q;
      r_d.restart = 1'b0;

      // Bus data phase bookkeeping
      r_d.dp_act = ap_take;
      r_d.dp_write = hwrite;
      r_d.dp_addr = ap_addr;

      // Read data is prepared in the address phase for zero wait states
      r_d.rdata = '0;
      if (ap_read) begin
         unique case (ap_addr)
            OFS_SCR: r_d.rdata[DATA_W-1:0] = scr_view;
            OFS_RESULT: r_d.rdata[DATA_W-1:0] = r_q.result;
            OFS_IRQ_STAT: r_d.rdata[0] = r_q.irq_stat;
            OFS_IRQ_MASK: r_d.rdata[0] = r_q.irq_mask;
            default: r_d.rdata = '0;
         endcase
      end

      // Clears first so that a completion in the same cycle wins
      if (rd_result) begin
         r_d.done = 1'b0;
         r_d.irq_stat = 1'b0;
      end
      if (wr_scr) begin
         r_d.irq_en = hwdata[SCR_IRQ_EN_BIT];
         r_d.cont = hwdata[SCR_CONT_BIT];
         r_d.sel = hwdata[SCR_SEL_LSB +: SEL_W];
         r_d.done = 1'b0;
         r_d.irq_stat = 1'b0;
         r_d.restart = powered(hwdata[SCR_SEL_LSB +: SEL_W]);
      end
      if (wr_stat && hwdata[0]) begin
         r_d.irq_stat = 1'b0;
      end
      if (wr_mask) begin
         r_d.irq_mask = hwdata[0];
      end

      // Core data is valid only with done; the write strobe is a cycle later
      if (core_done) begin
         r_d.core_hold = core_data;
      end

      // Conversion completion
      if (seq_we) begin
         r_d.result = r_q.core_hold;
         r_d.done = 1'b1;
         if (r_q.irq_en) begin
            r_d.irq_stat = 1'b1;
         end
      end

      // Registered power, route and pin outputs follow the next state of the select field, irq the next status and mask
      r_d.power_en = powered(r_d.sel);
      r_d.route = powered(r_d.sel) ? route_of(r_d.sel) : '0;
      r_d.pin_en = pins_of(r_d.sel);
      r_d.irq_out = r_d.irq_stat && r_d.irq_mask;
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         r_q.dp_act <= 1'b0;
         r_q.dp_write <= 1'b0;
         r_q.dp_addr <= '0;
         r_q.irq_en <= 1'b0;
         r_q.cont <= 1'b0;
         r_q.sel <= SEL_POWER_OFF;
         r_q.done <= 1'b0;
         r_q.result <= RESULT_RST;
         r_q.core_hold <= RESULT_RST;
         r_q.irq_stat <= 1'b0;
         r_q.irq_mask <= IRQ_MASK_RST;
         r_q.rdata <= '0;
         r_q.irq_out <= 1'b0;
         r_q.power_en <= 1'b0;
         r_q.route <= '0;
         r_q.pin_en <= '0;
         r_q.restart <= 1'b0;
      end else begin
         r_q <= r_d;
      end
   end

   // Slave never stalls and always answers OKAY
   assign hrdata = r_q.rdata;
   assign hreadyout = 1'b1;
   assign hresp = HRESP_OKAY;
   assign core_start = seq_start;
   assign core_power_en = r_q.power_en;
   assign analog_route = r_q.route;
   assign port_a_analog_en = r_q.pin_en;
   assign irq = r_q.irq_out;

endmodule : acc_conv_ctrl

/* File: acc_conv_ctrl_properties.sv */
// Port checker of the converter control block, bound to its top.
// Assumes hready is fed from hreadyout.
`timescale 1ns/1ns
module acc_conv_ctrl_chk (
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic hready,
   input wire logic [31:0] hrdata,
   input wire logic core_done,
   input wire logic core_start,
   input wire logic core_power_en,
   input wire logic [acc_pkg::ROUTE_W-1:0] analog_route,
   input wire logic [acc_pkg::PORT_A_W-1:0] port_a_analog_en,
   input wire logic irq
);
   import acc_pkg::*;
   logic acc, scr_wr, res_rd;
   default clocking cb @(posedge hclk); endclocking
   default disable iff (!hresetn);
   assign acc = hsel && hready && htrans[1];
   assign scr_wr = acc && hwrite && haddr[3:0] == OFS_SCR;
   assign res_rd = acc && !hwrite && haddr[3:0] == OFS_RESULT;
   power_off_a: assert property (!core_power_en |->
      analog_route == 6'h00 && port_a_analog_en == 8'h00)
      else $error("Routing active while powered off");
   route_onehot_a: assert property ($onehot0(analog_route))
      else $error("More than one input routed");
   pin_map_a: assert property (port_a_analog_en == {2'b00,
      analog_route[3:2], 2'b00, analog_route[1:0]})
      else $error("Port pin enables disagree with route");
   start_pulse_a: assert property (core_start |=> !core_start)
      else $error("Start longer than one cycle");
   upper_zero_a: assert property (hrdata[31:8] == 24'h000000)
      else $error("Read data upper bits not zero");
   start_cause_a: assert property (core_start |-> $past(core_done) ||
      $past(scr_wr, 2) || $past(scr_wr, 3))
      else $error("Start without write or completion");
   scr_clr_a: assert property (!core_done[*2] ##1 (scr_wr && !core_done)
      ##1 !core_done[*2] |=> !irq)
      else $error("Interrupt kept after control write");
   res_clr_a: assert property (!core_done[*2] ##1 (res_rd && !core_done)
      ##1 !core_done[*2] |=> !irq)
      else $error("Interrupt kept after result read");
endmodule : acc_conv_ctrl_chk

bind acc_conv_ctrl acc_conv_ctrl_chk u_chk (.hclk, .hresetn, .hsel, .haddr,
   .htrans, .hwrite, .hready, .hrdata, .core_done, .core_start,
   .core_power_en, .analog_route, .port_a_analog_en, .irq);

/* File: acc_core_model.sv */
// Behavioural conversion core: answers each start after a set delay.
// Assumes the bench sets the delay; a new start aborts the old one.
`timescale 1ns/1ns
module acc_core_model (
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic core_start,
   input wire logic [7:0] delay,
   output logic core_done,
   output logic [7:0] core_data,
   output logic [7:0] last_data
);
   logic [7:0] cnt_q;
   logic run_q;
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         cnt_q <= 8'h00;
         run_q <= 1'b0;
         core_done <= 1'b0;
         core_data <= 8'h00;
         last_data <= 8'h00;
      end else begin
         core_done <= 1'b0;
         // Data is only valid with done, so it toggles otherwise
         core_data <= ~core_data;
         if (core_start) begin
            run_q <= 1'b1;
            cnt_q <= delay;
         end else if (run_q && cnt_q == 8'h00) begin
            run_q <= 1'b0;
            core_done <= 1'b1;
            core_data <= last_data + 8'h11;
            last_data <= last_data + 8'h11;
         end else if (run_q) begin
            cnt_q <= cnt_q - 8'h01;
         end
      end
   end
endmodule : acc_core_model

/* File: tb.sv */
// Self-checking bench of the converter control block over AHB-Lite.
// Assumes the core model and the bound port checker.
`timescale 1ns/1ns
module tb;
   import acc_pkg::*;
   logic hclk, hresetn, hsel, hwrite, hreadyout, hresp, irq;
   logic core_done, core_start, core_power_en;
   logic [1:0] htrans;
   logic [2:0] hsize;
   logic [31:0] haddr, hwdata, hrdata, rd;
   logic [7:0] core_data, last_data, dly, port_a_analog_en;
   logic [5:0] analog_route;
   int err_count, checked, starts, base, i;
   // Only defined codes are used, unused ones would route nothing
   logic [4:0] codes [6] = '{5'h01, 5'h02, 5'h03, 5'h1D, 5'h1E, 5'h00};
   logic [5:0] routes [6] = '{6'h02, 6'h04, 6'h08, 6'h10, 6'h20, 6'h01};
   logic [7:0] pins [6] = '{8'h02, 8'h10, 8'h20, 8'h00, 8'h00, 8'h01};
   acc_conv_ctrl uut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
      .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
      .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
      .hreadyout(hreadyout), .hresp(hresp), .core_done(core_done),
      .core_data(core_data), .core_start(core_start),
      .core_power_en(core_power_en), .analog_route(analog_route),
      .port_a_analog_en(port_a_analog_en), .irq(irq));
   acc_core_model u_core (.hclk(hclk), .hresetn(hresetn),
      .core_start(core_start), .delay(dly), .core_done(core_done),
      .core_data(core_data), .last_data(last_data));
   initial begin
      hclk = 1'b0;
      forever #5 hclk = ~hclk;
   end
   always @(posedge hclk) if (core_start === 1'b1) starts <= starts + 1;
   task automatic chk(input string n, input logic [31:0] s,
         input logic [31:0] e);
      checked++;
      if (s !== e) begin
         err_count++;
         $display("Error %s expected %h seen %h", n, e, s);
      end
   endtask : chk
   task automatic bus(input logic w, input logic [3:0] a,
         input logic [31:0] d);
      hsel <= 1'b1;
      haddr <= {28'h0000000, a};
      htrans <= HTRANS_NONSEQ;
      hwrite <= w;
      @(posedge hclk);
      while (hreadyout !== 1'b1) @(posedge hclk);
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= d;
      @(posedge hclk);
      while (hreadyout !== 1'b1) @(posedge hclk);
      rd = hrdata;
   endtask : bus
   task automatic print_verdict;
      $display("Checks %0d errors %0d", checked, err_count);
      if (err_count == 0 && checked > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask : print_verdict
   initial begin
      repeat (5000) @(posedge hclk);
      err_count++;
      print_verdict();
   end
   initial begin
      hresetn = 1'b0;
      hsel = 1'b0;
      haddr = 32'h00000000;
      htrans = 2'h0;
      hwrite = 1'b0;
      hsize = 3'h2;
      hwdata = 32'h00000000;
      dly = 8'h03;
      starts = 0;
      repeat (5) @(posedge hclk);
      hresetn <= 1'b1;
      @(posedge hclk);
      chk("power rst", core_power_en, 1'b0);
      bus(1'b0, OFS_SCR, 32'h0);
      chk("scr rst", rd, 32'h0000001F);
      bus(1'b0, OFS_RESULT, 32'h0);
      chk("result rst", rd, 32'h0);
      bus(1'b1, OFS_IRQ_MASK, 32'h1);
      bus(1'b1, OFS_SCR, 32'h40);
      repeat (3) @(posedge hclk);
      chk("route ext0", analog_route, 6'h01);
      chk("pins ext0", port_a_analog_en, 8'h01);
      for (int k = 0; k < 300 && irq !== 1'b1; k++) @(posedge hclk);
      chk("irq done", irq, 1'b1);
      chk("settle starts", starts, 2);
      repeat (30) @(posedge hclk);
      chk("single starts", starts, 2);
      bus(1'b0, OFS_RESULT, 32'h0);
      chk("single result", rd, {24'h000000, last_data});
      repeat (2) @(posedge hclk);
      chk("irq read", irq, 1'b0);
      dly <= 8'h60;
      for (i = 0; i < 6; i++) begin
         base = starts;
         bus(1'b1, OFS_SCR, {27'h0000000, codes[i]});
         repeat (3) @(posedge hclk);
         chk("route", analog_route, routes[i]);
         chk("pins", port_a_analog_en, pins[i]);
         chk("restart", starts, base + 1);
      end
      dly <= 8'h02;
      base = starts;
      bus(1'b1, OFS_SCR, 32'h60);
      repeat (40) @(posedge hclk);
      chk("cont starts", starts > base + 4, 1'b1);
      // A long delay freezes the result so the read cannot race a done
      dly <= 8'hC8;
      repeat (10) @(posedge hclk);
      chk("irq cont", irq, 1'b1);
      bus(1'b1, OFS_IRQ_STAT, 32'h1);
      repeat (2) @(posedge hclk);
      chk("irq w1c", irq, 1'b0);
      bus(1'b0, OFS_RESULT, 32'h0);
      chk("cont result", rd, {24'h000000, last_data});
      // Let the slow conversion finish so the power-off write has work to do
      for (int k = 0; k < 300 && irq !== 1'b1; k++) @(posedge hclk);
      chk("irq slow", irq, 1'b1);
      bus(1'b1, OFS_SCR, 32'h1F);
      repeat (2) @(posedge hclk);
      chk("irq scr wr", irq, 1'b0);
      @(posedge hclk);
      base = starts;
      chk("power off", core_power_en, 1'b0);
      chk("route off", analog_route, 6'h00);
      repeat (250) @(posedge hclk);
      chk("off starts", starts, base);
      print_verdict();
   end
endmodule : tb
